// ==== src/fteg_event_gen.sv ====
`timescale 1ns/1ns
module fteg_event_gen (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration bus, classic wishbone
  input wire fteg_pkg::fteg_wb_req_t wb_req_i,
  output fteg_pkg::fteg_wb_rsp_t wb_rsp_o,
  // frame timers, same clock
  input wire fteg_pkg::fteg_time_t sys_time_i,
  input wire fteg_pkg::fteg_time_t rp3_time_i,
  input wire logic sys_resync_i,
  input wire logic rp3_resync_i,
  input wire logic first_sync_i,
  // events
  output logic [29:0] system_event_o,
  output logic antenna_frame_pulse_o,
  output logic local_frame_pulse_o
);

  fteg_pkg::fteg_state_t s_q;
  fteg_pkg::fteg_state_t s_d;

  ////////////////////////////////////////////////////////////////////////
  // per-generator timer view and compares
  fteg_pkg::fteg_time_t tm [fteg_pkg::NGEN];
  logic [fteg_pkg::NGEN-1:0] rsy;
  logic [fteg_pkg::NGEN-1:0] omt;
  logic [fteg_pkg::NGEN-1:0] hit;
  logic [fteg_pkg::NGEN-1:0] shit;

  genvar g;
  generate
    for (g = 0; g < fteg_pkg::NGEN; g++) begin : gen_cmp
      // timer select per generator
      assign tm[g] = s_q.ctrl[g][fteg_pkg::SEL_BIT] ? rp3_time_i : sys_time_i;
      // only the attached timer's resync touches this generator
      assign rsy[g] = s_q.ctrl[g][fteg_pkg::SEL_BIT] ? rp3_resync_i : sys_resync_i;
      // offset: slot, tc state, chip, sub-chip fields of the timer
      assign omt[g] = s_q.ctrl[g][fteg_pkg::OFS_W-1:0] == tm[g][fteg_pkg::OFS_W-1:0];
      // masked compare; empty mask never matches
      assign hit[g] = (|s_q.mask[g]) && (((tm[g][fteg_pkg::TRG_W-1:0] ^ s_q.trig[g])
                      & s_q.mask[g]) == '0);
      // sub-chip only compare for counter generators
      assign shit[g] = (|s_q.mask[g][2:0]) && (((tm[g].sub ^ s_q.trig[g][2:0])
                       & s_q.mask[g][2:0]) == 3'h0);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      wmerge[8*b +: 8] = s[b] ? d[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : wmerge

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [4:0] gi;
    logic [1:0] rg;
    logic [31:0] w;
    logic nm;
    s_d = s_q;
    gi = wb_req_i.adr[8:4];
    rg = wb_req_i.adr[3:2];
    w = fteg_pkg::RST_VAL;
    nm = 1'b0;
    s_d.ack = 1'b0;
    s_d.ev = '0;
    // bus: one-cycle ack, answer drops the cycle after
    if (wb_req_i.cyc && wb_req_i.stb && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdat = fteg_pkg::RST_VAL;
      if (gi < 5'(fteg_pkg::NGEN)) begin
        case (rg)
          fteg_pkg::REG_CTRL: begin
            s_d.rdat = 32'(s_q.ctrl[gi]);
          end
          fteg_pkg::REG_TRIG: begin
            s_d.rdat = 32'(s_q.trig[gi]);
          end
          fteg_pkg::REG_MASK: begin
            s_d.rdat = 32'(s_q.mask[gi]);
          end
          default: begin
            s_d.rdat = 32'(s_q.cntld[gi]);
          end
        endcase
        w = wmerge(s_d.rdat, wb_req_i.dat, wb_req_i.sel);
        if (wb_req_i.we) begin
          case (rg)
            fteg_pkg::REG_CTRL: begin
              s_d.ctrl[gi] = w[fteg_pkg::CTRL_W-1:0];
            end
            fteg_pkg::REG_TRIG: begin
              s_d.trig[gi] = w[fteg_pkg::TRG_W-1:0];
            end
            fteg_pkg::REG_MASK: begin
              s_d.mask[gi] = w[fteg_pkg::TRG_W-1:0];
            end
            default: begin
              s_d.cntld[gi] = w[fteg_pkg::CNT_W-1:0];
            end
          endcase
        end
      end else if (gi == fteg_pkg::STAT_GEN && rg == fteg_pkg::REG_CTRL) begin
        // read-only status: offset-met bits
        s_d.rdat = 32'(s_q.met);
      end
    end
    // generators
    for (int k = 0; k < fteg_pkg::NGEN; k++) begin
      // met holds from the matching cycle onward
      nm = s_q.met[k] | omt[k];
      s_d.met[k] = rsy[k] ? 1'b0 : nm;
      if (k >= fteg_pkg::CB_LO && k <= fteg_pkg::CB_HI) begin
        if (!s_q.ctrl[k][fteg_pkg::EN_BIT] || rsy[k]) begin
          s_d.run[k] = 1'b0;
        end else if (!s_q.run[k]) begin
          if (first_sync_i && nm) begin
            s_d.run[k] = 1'b1;
            s_d.cnt[k] = s_q.cntld[k];
          end
        end else if (shit[k]) begin
          // delay-1 loaded, event at zero then reload
          if (s_q.cnt[k] == '0) begin
            s_d.ev[k] = 1'b1;
            s_d.cnt[k] = s_q.cntld[k];
          end else begin
            s_d.cnt[k] = s_q.cnt[k] - 1'b1;
          end
        end
      end else begin
        // gated by offset, one pulse per matching cycle
        s_d.ev[k] = nm && !rsy[k] && hit[k];
      end
    end
    // frame pulses: retrigger ignored inside the 8-cycle window
    for (int f = 0; f < 2; f++) begin
      if (s_d.ev[f] && s_q.fcnt[f] == 3'h0) begin
        s_d.fcnt[f] = fteg_pkg::PULSE_LOAD;
      end else if (s_q.fcnt[f] != 3'h0) begin
        s_d.fcnt[f] = s_q.fcnt[f] - 3'h1;
      end
      s_d.fp[f] = s_d.fcnt[f] >= fteg_pkg::PULSE_HI_MIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset also disables all masks and counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign wb_rsp_o.ack = s_q.ack;
  assign wb_rsp_o.dat = s_q.rdat;
  assign system_event_o = s_q.ev;
  // single clock here: antenna side re-times it if needed
  assign antenna_frame_pulse_o = s_q.fp[1];
  assign local_frame_pulse_o = s_q.fp[0];

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // reset must be visible here, so this one is never disabled
  a_reset_clears_met: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
    (s_q.met == '0 && system_event_o == '0))
    else $error("reset left met or event set");

  a_mask_zero_quiet: assert property (s_q.mask[2] == '0 |=> !system_event_o[2])
    else $error("event with empty mask");

  a_offset_gates: assert property (!s_q.met[3] && !omt[3] |=> !system_event_o[3])
    else $error("event before offset met");

  a_resync_clears: assert property (rsy[4] |=> !s_q.met[4] && !system_event_o[4])
    else $error("resync did not clear met");

  a_other_timer_kept: assert property (!rsy[4] && s_q.met[4] |=> s_q.met[4])
    else $error("met lost without own resync");

  a_local_pulse_shape: assert property ($rose(local_frame_pulse_o) |->
    local_frame_pulse_o[*4] ##1 !local_frame_pulse_o[*4])
    else $error("local frame pulse shape wrong");

  a_ant_companion: assert property ($rose(antenna_frame_pulse_o) |-> system_event_o[1])
    else $error("antenna pulse without event 1");

  a_local_companion: assert property ($rose(local_frame_pulse_o) |-> system_event_o[0])
    else $error("local pulse without event 0");

  a_cnt_disabled: assert property (!s_q.ctrl[10][fteg_pkg::EN_BIT] |=>
    !system_event_o[10] && !s_q.run[10])
    else $error("disabled counter generator fired");

  a_cnt_start_wait: assert property (!s_q.run[11] && !first_sync_i |=> !s_q.run[11])
    else $error("counter started before first sync");

  a_cnt_reload: assert property (system_event_o[12] && $stable(s_q.cntld[12]) |->
    s_q.cnt[12] == s_q.cntld[12] && $past(s_q.cnt[12]) == '0)
    else $error("counter event not at zero");

  // bus answer: one registered ack per taken request
  a_bus_take_ack: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=>
    wb_rsp_o.ack)
    else $error("bus request not acked");

  a_bus_ack_once: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held longer than one cycle");

  // mask generators
  a_empty_mask_29: assert property (s_q.mask[29] == '0 |=> !system_event_o[29])
    else $error("event 29 with empty mask");

  a_mask_match_fires: assert property (s_q.met[2] && !rsy[2] && hit[2] |=>
    system_event_o[2])
    else $error("masked match gave no event");

  a_no_hit_quiet: assert property (!hit[2] |=> !system_event_o[2])
    else $error("event without masked match");

  a_resync_mask_quiet: assert property (rsy[2] |=> !system_event_o[2])
    else $error("event in resync cycle");

  a_met_sticky: assert property (s_q.met[2] && !rsy[2] |=> s_q.met[2])
    else $error("offset met dropped");

  a_met_on_match: assert property (omt[2] && !rsy[2] |=> s_q.met[2])
    else $error("offset match not latched");

  a_offset_gates_18: assert property (!s_q.met[18] && !omt[18] |=>
    !system_event_o[18])
    else $error("event 18 before offset met");

  a_rp3_met_kept: assert property (!rsy[18] && s_q.met[18] |=> s_q.met[18])
    else $error("met 18 lost without own resync");

  // frame pulses
  a_ant_pulse_shape: assert property ($rose(antenna_frame_pulse_o) |->
    antenna_frame_pulse_o[*4] ##1 !antenna_frame_pulse_o[*4])
    else $error("antenna frame pulse shape wrong");

  a_local_low_gap: assert property ($fell(local_frame_pulse_o) |->
    !local_frame_pulse_o[*4])
    else $error("local frame pulse low too short");

  a_local_rise_load: assert property ($rose(local_frame_pulse_o) |->
    s_q.fcnt[0] == fteg_pkg::PULSE_LOAD)
    else $error("local pulse rose without window load");

  // counter generators
  a_cnt_resync_stop: assert property (rsy[13] |=> !s_q.run[13])
    else $error("counter kept running over resync");

  a_cnt_need_met: assert property (!s_q.run[14] && !s_q.met[14] && !omt[14] |=>
    !s_q.run[14])
    else $error("counter started before offset met");

  a_cnt_idle_quiet: assert property (!s_q.run[12] |=> !system_event_o[12])
    else $error("idle counter fired");

  a_cnt_event_run: assert property (system_event_o[12] |-> $past(s_q.run[12]))
    else $error("counter event without run");

  a_cnt_step: assert property (s_q.ctrl[12][fteg_pkg::EN_BIT] && !rsy[12] &&
    s_q.run[12] && shit[12] && s_q.cnt[12] != '0 |=>
    s_q.cnt[12] == $past(s_q.cnt[12]) - 16'h1)
    else $error("counter did not step on sub-chip match");

  a_cnt_hold: assert property (s_q.ctrl[12][fteg_pkg::EN_BIT] && !rsy[12] &&
    s_q.run[12] && !shit[12] |=> $stable(s_q.cnt[12]))
    else $error("counter moved without sub-chip match");

  a_cnt_start_load: assert property ($rose(s_q.run[12]) |->
    s_q.cnt[12] == $past(s_q.cntld[12]))
    else $error("counter start without reload");

  a_cnt_disabled_15: assert property (!s_q.ctrl[15][fteg_pkg::EN_BIT] |=>
    !system_event_o[15])
    else $error("disabled counter 15 fired");

  a_cnt_sync_16: assert property (!s_q.run[16] && !first_sync_i |=>
    !system_event_o[16])
    else $error("counter 16 fired before sync");

endmodule : fteg_event_gen

// ==== src/fteg_pkg.sv ====
package fteg_pkg;
  localparam int NGEN = 30;
  localparam int CB_LO = 10;
  localparam int CB_HI = 17;
  localparam int OFS_W = 21;
  localparam int TRG_W = 23;
  localparam int CNT_W = 16;
  localparam int CTRL_W = 29;
  localparam int SEL_BIT = 24;
  localparam int EN_BIT = 28;
  localparam int CHIPS_PER_SLOT = 2560;
  localparam int SLOTS_PER_FRAME = 15;
  // register offsets inside one generator's 16-byte window
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_TRIG = 2'h1;
  localparam logic [1:0] REG_MASK = 2'h2;
  localparam logic [1:0] REG_CNT = 2'h3;
  localparam logic [4:0] STAT_GEN = 5'h1f;
  // frame pulse stretch: 8-cycle window, high while count above 3
  localparam logic [2:0] PULSE_LOAD = 3'h7;
  localparam logic [2:0] PULSE_HI_MIN = 3'h4;
  localparam logic [31:0] RST_VAL = 32'h0;

  // timer value, eighth-chip resolution, high bits first
  typedef struct packed {
    logic [11:0] frame;
    logic [3:0] slot;
    logic [1:0] tc;
    logic [11:0] chip;
    logic [2:0] sub;
  } fteg_time_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [8:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } fteg_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } fteg_wb_rsp_t;

  typedef struct packed {
    logic [NGEN-1:0][CTRL_W-1:0] ctrl;
    logic [NGEN-1:0][TRG_W-1:0] trig;
    logic [NGEN-1:0][TRG_W-1:0] mask;
    logic [NGEN-1:0][CNT_W-1:0] cntld;
    logic [NGEN-1:0][CNT_W-1:0] cnt;
    logic [NGEN-1:0] met;
    logic [NGEN-1:0] run;
    logic [NGEN-1:0] ev;
    logic [1:0][2:0] fcnt;
    logic [1:0] fp;
    logic ack;
    logic [31:0] rdat;
  } fteg_state_t;
endpackage : fteg_pkg

// ==== testbench/fteg_timer_model.sv ====
`timescale 1ns/1ns
// frame timer stand-in: one eighth-chip step per clock, terminal-count state kept at 0
module fteg_timer_model #(
  parameter fteg_pkg::fteg_time_t LOAD = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // resync reloads the count
  input wire logic resync_i,
  // timer value
  output fteg_pkg::fteg_time_t time_o
);
  localparam logic [11:0] CHIP_LAST = 12'(fteg_pkg::CHIPS_PER_SLOT - 1);
  localparam logic [3:0] SLOT_LAST = 4'(fteg_pkg::SLOTS_PER_FRAME - 1);
  ////////////////////////////////////////
  // count sub-chip, chip, slot, frame
  always_ff @(posedge clk_i) begin
    if (rst_i || resync_i) begin
      time_o <= LOAD;
    end else begin
      time_o.sub <= time_o.sub + 3'h1;
      if (time_o.sub == 3'h7) begin
        time_o.chip <= (time_o.chip == CHIP_LAST) ? 12'h0 : time_o.chip + 12'h1;
        if (time_o.chip == CHIP_LAST) begin
          time_o.slot <= (time_o.slot == SLOT_LAST) ? 4'h0 : time_o.slot + 4'h1;
          if (time_o.slot == SLOT_LAST) begin
            time_o.frame <= time_o.frame + 12'h1;
          end
        end
      end
    end
  end
endmodule : fteg_timer_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [4:0] g;
    logic sel;
    logic [20:0] ofs;
    logic [22:0] trg;
    logic [22:0] msk;
  } fteg_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sys_rs = 1'b0;
  logic rp3_rs = 1'b0;
  logic first_sync = 1'b0;
  fteg_pkg::fteg_wb_req_t req = '0;
  fteg_pkg::fteg_wb_rsp_t rsp;
  fteg_pkg::fteg_time_t st, rt;
  logic [29:0] ev;
  logic afp, lfp, on = 1'b0, met_q = 1'b0, ev_q = 1'b0;
  logic [31:0] r;
  int n_fail = 0, n_compared = 0, cycles = 0, n;
  int hr [2] = '{0, 0};
  fteg_row_t m = '0;
  // generator, timer select, offset, trigger, mask; periods kept legal
  fteg_row_t rows [6] = '{'{5'h2, 1'b0, 21'h10, 23'h5, 23'h7},
    '{5'h1d, 1'b0, 21'h0, 23'h7fffff, 23'h0}, '{5'h12, 1'b1, 21'h18, 23'h1, 23'h1},
    '{5'h0, 1'b0, 21'h0, 23'h0, 23'h7}, '{5'h1, 1'b1, 21'h20, 23'h3, 23'h7},
    '{5'h5, 1'b0, 21'h0, 23'h7fffff, 23'h7fffff}};
  fteg_event_gen u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .sys_time_i(st), .rp3_time_i(rt), .sys_resync_i(sys_rs), .rp3_resync_i(rp3_rs),
    .first_sync_i(first_sync), .system_event_o(ev), .antenna_frame_pulse_o(afp),
    .local_frame_pulse_o(lfp));
  fteg_timer_model u_sys (.clk_i(clk_i), .rst_i(rst_i), .resync_i(sys_rs), .time_o(st));
  // rp3 starts off the system count so a wrong timer select shows
  fteg_timer_model #(.LOAD(33'h14)) u_rp3 (.clk_i(clk_i), .rst_i(rst_i),
    .resync_i(rp3_rs), .time_o(rt));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // one classic cycle; read data taken at the negedge that sees ack high
  task automatic wb(input logic we, input logic [8:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    // look at ack mid-cycle, then release at the edge that samples it high
    do begin
      @(negedge clk_i);
      k++;
    end while (rsp.ack !== 1'b1 && k < 20);
    r = rsp.dat;
    @(posedge clk_i);
    req <= '0;
    if (k == 20) n_fail++;
  endtask : wb
  task automatic rs(input logic s, input logic p);
    @(posedge clk_i);
    sys_rs <= s;
    rp3_rs <= p;
    @(posedge clk_i);
    sys_rs <= 1'b0;
    rp3_rs <= 1'b0;
  endtask : rs
  // cycles until counter event 12, len if none
  task automatic wait_ev(input int len);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ev[12] !== 1'b1 && n < len);
  endtask : wait_ev
  ////////////////////////////////////////
  // expected mask event of the generator under test, plus run ceiling
  always @(posedge clk_i) begin
    logic [32:0] t;
    t = m.sel ? rt : st;
    if ((m.sel ? rp3_rs : sys_rs) === 1'b1) begin
      met_q <= 1'b0;
      ev_q <= 1'b0;
    end else begin
      met_q <= met_q | (t[20:0] == m.ofs);
      ev_q <= (met_q | (t[20:0] == m.ofs)) & (m.msk != '0) & (((t[22:0] ^ m.trg) & m.msk) == '0);
    end
    cycles++;
    if (cycles > 5000) begin
      n_fail++;
      end_sim();
    end
  end
  // compare events and frame pulse high widths where settled
  always @(negedge clk_i) begin
    if (on) chk(32'(ev[m.g]), 32'(ev_q));
    for (int k = 0; k < 2; k++) begin
      if ((k ? afp : lfp) === 1'b1) hr[k]++;
      else begin
        if (hr[k] != 0) chk(32'(hr[k]), 32'h4);
        hr[k] = 0;
      end
    end
  end
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({2'h0, ev}, 32'h0);
    wb(1'b0, 9'h1f0, 32'h0);
    chk(r, 32'h3fff_ffff);
    wb(1'b0, 9'h1e4, 32'h0);
    chk(r, 32'h0);
    foreach (rows[i]) begin
      wb(1'b1, {rows[i].g, 4'h0}, 32'(rows[i].ofs) | (32'(rows[i].sel) << fteg_pkg::SEL_BIT));
      wb(1'b1, {rows[i].g, 4'h4}, 32'(rows[i].trg));
      wb(1'b1, {rows[i].g, 4'h8}, 32'(rows[i].msk));
      wb(1'b0, {rows[i].g, 4'h4}, 32'h0);
      chk(r, 32'(rows[i].trg));
      m <= rows[i];
      rs(1'b1, 1'b1);
      on = 1'b1;
      repeat (32) @(posedge clk_i);
      rs(1'b1, 1'b0);
      repeat (40) @(posedge clk_i);
      on = 1'b0;
    end
    // counter generator 12: sub-chip 0 step, delay three steps
    wb(1'b1, 9'h0c8, 32'h7);
    wb(1'b1, 9'h0cc, 32'h2);
    wb(1'b1, 9'h0c0, 32'h1000_0000);
    rs(1'b1, 1'b0);
    wait_ev(64);
    chk(32'(n), 32'd64);
    @(posedge clk_i);
    first_sync <= 1'b1;
    rs(1'b1, 1'b0);
    wait_ev(100);
    wait_ev(100);
    chk(32'(n), 32'd24);
    wb(1'b1, 9'h0c0, 32'h0);
    wait_ev(64);
    chk(32'(n), 32'd64);
    // mid-run reset: events quiet, settings back to zero
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({2'h0, ev}, 32'h0);
    wb(1'b0, 9'h028, 32'h0);
    chk(r, 32'h0);
    end_sim();
  end
endmodule : tb_top
